/* common/nvsram_host_regs.svh */
// Timing counts and pin-level constants for the nvSRAM host controller
`ifndef NVSRAM_HOST_REGS_SVH
`define NVSRAM_HOST_REGS_SVH
// Clock period in ps (250 MHz)
`define CLK_PERIOD_PS 4000
// Device timing figures in ps (slowest speed grade defaults)
`define ADDRESS_ACCESS_TIME_PS 45000
`define SELECT_ACCESS_TIME_PS 45000
`define OUTPUT_ACCESS_TIME_PS 20000
`define WRITE_DATA_SETUP_PS 15000
`define WRITE_TO_FLOAT_DELAY_PS 15000
`define ADDRESS_SETUP_PS 4000
// Least times round up to whole cycles
`define ACCESS_CYCLES ((`SELECT_ACCESS_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETUP_CYCLES ((`WRITE_DATA_SETUP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define FLOAT_CYCLES ((`WRITE_TO_FLOAT_DELAY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ADDR_SETUP_CYCLES ((`ADDRESS_SETUP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TIMER_WIDTH 8
// Software store and recall address sequence
`define SEQ_ADDR_0 13'h0000
`define SEQ_ADDR_1 13'h1555
`define SEQ_ADDR_2 13'h0aaa
`define SEQ_ADDR_3 13'h1fff
`define SEQ_ADDR_4 13'h10f0
`define SEQ_STORE_ADDR 13'h0f0f
`define SEQ_RECALL_ADDR 13'h0f0e
`define SEQ_LENGTH 6
`define ADDR_WIDTH 13
`define DATA_WIDTH 8
// Command codes
`define CMD_READ 2'h0
`define CMD_WRITE 2'h1
`define CMD_SW_STORE 2'h2
`define CMD_SW_RECALL 2'h3
`endif

/* common/nvsram_host_pkg.sv */
// Types for the nvSRAM host controller
package nvsram_host_pkg;
	typedef struct packed {
		logic [1:0] cmd;
		logic [12:0] addr;
		logic [7:0] wdata;
	} host_req_type;
	typedef struct packed {
		logic select_n;
		logic write_n;
		logic output_n;
		logic [12:0] address_lines;
	} pin_ctrl_type;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_READ = 7'h02,
		ST_WR_SETUP = 7'h04,
		ST_WRITE = 7'h08,
		ST_RECOVER = 7'h10,
		ST_SEQ = 7'h20,
		ST_BUSY = 7'h40
	} host_state_type;
endpackage

/* rtl/nvsram_seq_rom.sv */
// Address lookup for the software store and recall read sequences
`timescale 1ns/1ps
`include "nvsram_host_regs.svh"
module nvsram_seq_rom (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] index,
	input wire logic recall,
	output logic [12:0] seq_addr
);
	// ==========================================
	// Registered lookup
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_addr <= 13'h0000;
		end else begin
			unique case (index)
				3'h0: seq_addr <= `SEQ_ADDR_0;
				3'h1: seq_addr <= `SEQ_ADDR_1;
				3'h2: seq_addr <= `SEQ_ADDR_2;
				3'h3: seq_addr <= `SEQ_ADDR_3;
				3'h4: seq_addr <= `SEQ_ADDR_4;
				default: seq_addr <= recall ? `SEQ_RECALL_ADDR : `SEQ_STORE_ADDR;
			endcase
		end
	end
endmodule

/* rtl/nvsram_host_ctrl.sv */
// Host controller driving the pins of an 8K x 8 nonvolatile static RAM
`timescale 1ns/1ps
`include "nvsram_host_regs.svh"
module nvsram_host_ctrl
	import nvsram_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire host_req_type req,
	input wire logic hw_store_req,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic nv_busy,
	output logic write_pending,
	output pin_ctrl_type pins,
	input wire logic [7:0] data_lines_in,
	output logic [7:0] data_lines_out,
	output logic data_lines_oe,
	input wire logic store_busy_n_in,
	output logic store_busy_n_out,
	output logic store_busy_n_oe
);
	localparam logic [7:0] ACCESS_CNT = 8'(`ACCESS_CYCLES);
	localparam logic [7:0] SETUP_CNT = 8'(`SETUP_CYCLES);
	localparam logic [7:0] ADDR_SETUP_CNT = 8'(`ADDR_SETUP_CYCLES);

	host_state_type state_reg;
	logic [7:0] timer_reg;
	logic [2:0] seq_index_reg;
	logic seq_recall_reg;
	logic [1:0] cmd_reg;
	logic [12:0] addr_reg;
	logic [7:0] wdata_reg;
	logic busy_seen_reg;
	logic [12:0] seq_addr;
	logic timer_done;

	assign timer_done = (timer_reg == 8'h00);

	function automatic logic is_sw_cmd(input logic [1:0] c);
		return (c == `CMD_SW_STORE) || (c == `CMD_SW_RECALL);
	endfunction

	nvsram_seq_rom nvsram_seq_rom_inst (
		.clk(clk),
		.rst_n(rst_n),
		.index(seq_index_reg),
		.recall(seq_recall_reg),
		.seq_addr(seq_addr)
	);

	// ==========================================
	// Request acceptance
	// All requests held off while the device reports busy
	assign req_ready = (state_reg == ST_IDLE) && store_busy_n_in;
	assign nv_busy = !store_busy_n_in;

	// ==========================================
	// Main sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			timer_reg <= 8'h00;
			seq_index_reg <= 3'h0;
			seq_recall_reg <= 1'b0;
			cmd_reg <= `CMD_READ;
			addr_reg <= 13'h0000;
			wdata_reg <= 8'h00;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (req_valid && req_ready) begin
						cmd_reg <= req.cmd;
						addr_reg <= req.addr;
						wdata_reg <= req.wdata;
						if (is_sw_cmd(req.cmd)) begin
							// Sequence runs without any other access between its reads
							seq_index_reg <= 3'h0;
							seq_recall_reg <= (req.cmd == `CMD_SW_RECALL);
							timer_reg <= 8'h01;
							state_reg <= ST_SEQ;
						end else if (req.cmd == `CMD_WRITE) begin
							timer_reg <= ADDR_SETUP_CNT;
							state_reg <= ST_WR_SETUP;
						end else begin
							timer_reg <= ACCESS_CNT;
							state_reg <= ST_READ;
						end
					end
				end
				ST_SEQ: begin
					// Two cycles for the registered lookup, then a full read of that address
					if (timer_done) begin
						addr_reg <= seq_addr;
						timer_reg <= ACCESS_CNT;
						state_reg <= ST_READ;
					end else begin
						timer_reg <= timer_reg - 8'h01;
					end
				end
				ST_READ: begin
					if (timer_done) begin
						timer_reg <= 8'h01;
						if (is_sw_cmd(cmd_reg) && seq_index_reg != 3'(`SEQ_LENGTH - 1)) begin
							seq_index_reg <= seq_index_reg + 3'h1;
							state_reg <= ST_SEQ;
						end else begin
							state_reg <= ST_RECOVER;
						end
					end else begin
						timer_reg <= timer_reg - 8'h01;
					end
				end
				ST_WR_SETUP: begin
					if (timer_done) begin
						timer_reg <= SETUP_CNT;
						state_reg <= ST_WRITE;
					end else begin
						timer_reg <= timer_reg - 8'h01;
					end
				end
				ST_WRITE: begin
					if (timer_done) begin
						timer_reg <= 8'h01;
						state_reg <= ST_RECOVER;
					end else begin
						timer_reg <= timer_reg - 8'h01;
					end
				end
				ST_RECOVER: begin
					// Software commands wait for the device to report busy and finish
					if (timer_done) begin
						state_reg <= is_sw_cmd(cmd_reg) ? ST_BUSY : ST_IDLE;
					end else begin
						timer_reg <= timer_reg - 8'h01;
					end
				end
				ST_BUSY: begin
					if (busy_seen_reg && store_busy_n_in) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Busy observation for software transfers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_seen_reg <= 1'b0;
		end else if (state_reg == ST_IDLE) begin
			busy_seen_reg <= 1'b0;
		end else if (!store_busy_n_in) begin
			busy_seen_reg <= 1'b1;
		end
	end

	// ==========================================
	// Pin drivers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins <= '{select_n: 1'b1, write_n: 1'b1, output_n: 1'b1, address_lines: 13'h0000};
			data_lines_out <= 8'h00;
			data_lines_oe <= 1'b0;
		end else begin
			pins.address_lines <= addr_reg;
			pins.select_n <= !(state_reg == ST_READ || state_reg == ST_WRITE);
			pins.write_n <= !(state_reg == ST_WRITE);
			// Output enable only for plain reads; never during writes
			pins.output_n <= !(state_reg == ST_READ && cmd_reg == `CMD_READ);
			data_lines_out <= wdata_reg;
			data_lines_oe <= (state_reg == ST_WR_SETUP || state_reg == ST_WRITE);
		end
	end

	// ==========================================
	// Read data capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
		end else begin
			rsp_valid <= 1'b0;
			if (state_reg == ST_READ && timer_done && cmd_reg == `CMD_READ) begin
				rsp_valid <= 1'b1;
				rsp_rdata <= data_lines_in;
			end
		end
	end

	// ==========================================
	// Hardware store request on the open-drain pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_pending <= 1'b0;
		end else if (state_reg == ST_WRITE && timer_done) begin
			write_pending <= 1'b1;
		end else if (!store_busy_n_in && !store_busy_n_oe) begin
			write_pending <= 1'b0;
		end else if (state_reg == ST_BUSY && busy_seen_reg && store_busy_n_in) begin
			write_pending <= 1'b0;
		end
	end

	assign store_busy_n_out = 1'b0;
	// Pull low only when started from idle, released as soon as the pin reads low, which its own pull causes one cycle later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			store_busy_n_oe <= 1'b0;
		end else if (store_busy_n_oe) begin
			store_busy_n_oe <= store_busy_n_in;
		end else begin
			store_busy_n_oe <= hw_store_req && write_pending && state_reg == ST_IDLE && store_busy_n_in;
		end
	end
endmodule

/* test/nvsram_host_properties.sv */
// Assertions on the nvSRAM host controller ports
`timescale 1ns/1ps
module nvsram_host_properties
	import nvsram_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire host_req_type req,
	input wire logic hw_store_req,
	input wire logic rsp_valid,
	input wire logic nv_busy,
	input wire logic write_pending,
	input wire pin_ctrl_type pins,
	input wire logic [7:0] data_lines_out,
	input wire logic data_lines_oe,
	input wire logic store_busy_n_in,
	input wire logic store_busy_n_out,
	input wire logic store_busy_n_oe
);
	// ==========
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (req_valid && req_ready && req.cmd == 2'h0 |-> ##[13:14] rsp_valid)
		else $error("read answer late");
	a_write_oe_high: assert property (!pins.write_n |-> pins.output_n && data_lines_oe)
		else $error("write without data drive");
	a_read_no_drive: assert property (!pins.output_n |-> !data_lines_oe && pins.write_n)
		else $error("bus contention on read");
	a_addr_hold: assert property (!pins.write_n |=> pins.write_n || $stable(pins.address_lines))
		else $error("address moved in write");
	a_data_setup: assert property ($fell(pins.write_n) |->
		(!pins.write_n && !pins.select_n && data_lines_oe && $stable(data_lines_out))[*4])
		else $error("write data setup short");
	a_no_busy_write: assert property ($fell(pins.write_n) |-> $past(store_busy_n_in))
		else $error("write begun while busy");
	a_busy_blocks: assert property (!store_busy_n_in |-> !req_ready && nv_busy)
		else $error("request taken while busy");
	a_hw_needs_write: assert property ($rose(store_busy_n_oe) |-> $past(write_pending) && $past(hw_store_req))
		else $error("store pull without write");
	a_pull_low: assert property (store_busy_n_oe |-> store_busy_n_out == 1'b0)
		else $error("store pin driven high");
	c_read: cover property (rsp_valid);
	c_write: cover property ($fell(pins.write_n));
	c_hw_store: cover property ($rose(store_busy_n_oe));
	c_dev_busy: cover property (!store_busy_n_in && !store_busy_n_oe);
endmodule

/* test/nvsram_device_model.sv */
// Behavioural model of the nonvolatile static RAM at its pins
`timescale 1ns/1ps
`include "nvsram_host_regs.svh"
module nvsram_device_model
	import nvsram_host_pkg::*;
(
	input wire logic clk,
	input wire pin_ctrl_type pins,
	input wire logic [7:0] host_data,
	input wire logic host_oe,
	input wire logic host_pull,
	input wire logic [7:0] busy_len,
	output logic [7:0] bus,
	output logic busy_pin
);
	// ==========
	// Array and pins
	localparam logic [12:0] seq_table [5] = '{`SEQ_ADDR_0, `SEQ_ADDR_1, `SEQ_ADDR_2, `SEQ_ADDR_3, `SEQ_ADDR_4};
	logic [7:0] ram [8192];
	logic [7:0] nv [8192];
	logic [7:0] rd_now, last_bus;
	logic [7:0] cnt_reg = 8'h00;
	logic [2:0] step_reg = 3'h0;
	logic dirty_reg = 1'b0;
	logic sel_q = 1'b1;
	logic [12:0] a;
	assign a = pins.address_lines;
	assign #45 rd_now = ram[a];
	assign busy_pin = !(host_pull || cnt_reg != 8'h00);
	// Floating bus toggles so stale data never reads as valid
	assign bus = host_oe ? host_data : (!pins.select_n && !pins.output_n && pins.write_n && busy_pin) ? rd_now : ~last_bus;
	task automatic move_all(input logic to_nv);
		for (int i = 0; i < 8192; i++) begin
			if (to_nv) nv[i] = ram[i];
			else ram[i] = nv[i];
		end
	endtask
	always @(posedge clk) begin
		last_bus <= bus;
		sel_q <= pins.select_n;
		if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end else if (host_pull && dirty_reg) begin
			move_all(1'b1);
			dirty_reg <= 1'b0;
			cnt_reg <= busy_len;
		end else if (sel_q && !pins.select_n && pins.write_n) begin
			if (step_reg == 3'h5 && (a == `SEQ_STORE_ADDR || a == `SEQ_RECALL_ADDR)) begin
				move_all(a == `SEQ_STORE_ADDR);
				dirty_reg <= 1'b0;
				cnt_reg <= busy_len;
				step_reg <= 3'h0;
			end else if (step_reg < 3'h5 && a == seq_table[step_reg]) begin
				step_reg <= step_reg + 3'h1;
			end else begin
				step_reg <= {2'h0, a == `SEQ_ADDR_0};
			end
		end else if (!pins.select_n && !pins.write_n && busy_pin) begin
			ram[a] = bus;
			dirty_reg <= 1'b1;
			step_reg <= 3'h0;
		end
	end
endmodule

/* test/nvsram_async_port_test.sv */
// Testbench driving the host controller against the device model
`timescale 1ns/1ps
module nvsram_async_port_test
	import nvsram_host_pkg::*;
();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic hw_store_req = 1'b0;
	host_req_type req = '0;
	logic [7:0] busy_len = 8'h14;
	logic req_ready, rsp_valid, nv_busy, write_pending, data_lines_oe, store_busy_n_in, store_busy_n_out, store_busy_n_oe;
	logic [7:0] rsp_rdata, data_lines_out, data_lines_in;
	pin_ctrl_type pins;
	logic [7:0] exp_q [$];
	logic [12:0] ad [6];
	logic [7:0] dt [6];
	int n_mismatch = 0;
	int checks_done = 0;
	int seed = 32'h3e187a50;
	always #2 clk = ~clk;
	nvsram_host_ctrl nvsram_host_ctrl_inst (.clk, .rst_n, .req_valid, .req_ready, .req, .hw_store_req, .rsp_valid,
		.rsp_rdata, .nv_busy, .write_pending, .pins, .data_lines_in, .data_lines_out, .data_lines_oe, .store_busy_n_in,
		.store_busy_n_out, .store_busy_n_oe);
	nvsram_device_model nvsram_device_model_inst (.clk, .pins, .host_data(data_lines_out), .host_oe(data_lines_oe),
		.host_pull(store_busy_n_oe && !store_busy_n_out), .busy_len, .bus(data_lines_in), .busy_pin(store_busy_n_in));
	// ==========
	// Tasks
	task automatic cmp8(input string what, input logic [7:0] expv, input logic [7:0] got);
		checks_done++;
		if (got !== expv) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, expv, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wait_on(input logic want_busy);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (n > 6000) begin
				n_mismatch++;
				$display("Error %s expected 1 seen %b", want_busy ? "nv_busy" : "req_ready", want_busy ? nv_busy : req_ready);
				tally_and_finish();
			end
		end while ((want_busy ? nv_busy : req_ready) !== 1'b1);
	endtask
	task automatic send(input logic [1:0] c, input logic [12:0] a, input logic [7:0] d);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{cmd: c, addr: a, wdata: d};
		wait_on(1'b0);
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		send(2'h0, a, 8'h00);
	endtask
	// Sampled half a cycle after launch so the registered pulse has settled
	always @(negedge clk) begin
		if (rst_n && rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("Error rsp_rdata expected none seen %h", rsp_rdata);
			end else begin
				cmp8("rsp_rdata", exp_q.pop_front(), rsp_rdata);
			end
		end
	end
	// ==========
	// Scenarios
	initial begin
		logic k;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			ad[i] = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : {3'(i), 10'($random(seed))};
			dt[i] = 8'($random(seed));
			send(2'h1, ad[i], dt[i]);
			rd(ad[i], dt[i]);
		end
		cmp8("write_pending", 8'h01, {7'h00, write_pending});
		send(2'h2, 13'h0000, 8'h00);
		wait_on(1'b0);
		cmp8("write_pending", 8'h00, {7'h00, write_pending});
		send(2'h1, ad[2], ~dt[2]);
		rd(ad[2], ~dt[2]);
		send(2'h3, 13'h0000, 8'h00);
		for (int i = 0; i < 6; i++) begin
			rd(ad[i], dt[i]);
		end
		dt[3] = ~dt[3];
		send(2'h1, ad[3], dt[3]);
		busy_len <= 8'hc8;
		wait_on(1'b0);
		@(posedge clk);
		hw_store_req <= 1'b1;
		wait_on(1'b1);
		cmp8("req_ready", 8'h00, {7'h00, req_ready});
		@(posedge clk);
		hw_store_req <= 1'b0;
		wait_on(1'b0);
		cmp8("write_pending", 8'h00, {7'h00, write_pending});
		@(posedge clk);
		hw_store_req <= 1'b1;
		k = 1'b0;
		repeat (40) begin
			@(negedge clk);
			k = k | (nv_busy !== 1'b0);
		end
		cmp8("nv_busy", 8'h00, {7'h00, k});
		@(posedge clk);
		hw_store_req <= 1'b0;
		send(2'h3, 13'h0000, 8'h00);
		rd(ad[3], dt[3]);
		wait_on(1'b0);
		repeat (3) @(negedge clk);
		cmp8("exp_q", 8'h00, 8'(exp_q.size()));
		tally_and_finish();
	end
endmodule
bind nvsram_host_ctrl nvsram_host_properties nvsram_host_properties_inst (.clk, .rst_n, .req_valid, .req_ready, .req,
	.hw_store_req, .rsp_valid, .nv_busy, .write_pending, .pins, .data_lines_out, .data_lines_oe, .store_busy_n_in,
	.store_busy_n_out, .store_busy_n_oe);
